// >>> logic/bfps_sequencer.v
// Purpose: supervisory and sequencing logic of a synchronous buck regulator
// Assumes: comparator flags are asynchronous levels; freq_set_period is the
//          oscillator period in mclk cycles decoded from the frequency resistor
// Notes:   all state freezes while clk_en is low
`include "bfps_regs.vh"

module bfps_sequencer (
    input  wire        mclk,
    input  wire        reset_n,
    input  wire        clk_en,
    input  wire [11:0] freq_set_period,
    input  wire        sync_clk_in,
    input  wire        en_above_on,
    input  wire        en_below_off,
    input  wire        vin_above_rise,
    input  wire        vin_below_fall,
    input  wire        temp_over_hot,
    input  wire        temp_below_cool,
    input  wire        fb_over_ov,
    input  wire        fb_below_ov_release,
    input  wire        fb_above_window,
    input  wire        fb_below_window,
    input  wire        fb_above_fold_hi,
    input  wire        fb_above_fold_lo,
    input  wire        peak_ilim,
    input  wire        pwm_peak_trip,
    input  wire        sink_ilim,
    input  wire        zero_cross,
    input  wire        ss_above_fb,
    input  wire [10:0] ext_ss_level,
    input  wire        regulation_ok_in,
    output wire        regulation_ok_out,
    output wire        regulation_ok_oe,
    output reg         hs_gate,
    output reg         ls_gate,
    output reg  [10:0] target_level,
    output wire        continuous_conduction,
    output reg         reverse_block,
    output wire        hiccup_active,
    output wire        soft_start_active,
    output reg  [3:0]  oc_count,
    output reg         sync_locked,
    output reg  [1:0]  fold_div
);

    localparam [2:0] ST_OFF = 3'd0;
    localparam [2:0] ST_SS  = 3'd1;
    localparam [2:0] ST_RUN = 3'd2;
    localparam [2:0] ST_HIC = 3'd3;
    localparam [2:0] ST_TSD = 3'd4;

    localparam integer SYNC_MIN_I   = `BFPS_SYNC_PER_MIN;
    localparam integer SYNC_MAX_I   = `BFPS_SYNC_PER_MAX;
    localparam [9:0]   SYNC_PER_MIN = SYNC_MIN_I[9:0];
    localparam [9:0]   SYNC_PER_MAX = SYNC_MAX_I[9:0];

    // comparator synchronizers
    wire [`BFPS_NUM_CMP-1:0] cmp_raw;
    reg  [`BFPS_NUM_CMP-1:0] cmp_meta_reg;
    reg  [`BFPS_NUM_CMP-1:0] cmp_sync_reg;

    assign cmp_raw = {zero_cross, ss_above_fb, sink_ilim, pwm_peak_trip,
                      peak_ilim, fb_above_fold_lo, fb_above_fold_hi,
                      fb_below_window, fb_above_window, fb_below_ov_release,
                      fb_over_ov, temp_below_cool, temp_over_hot,
                      vin_below_fall, vin_above_rise, en_above_on};

    genvar gi;
    generate
        for (gi = 0; gi < `BFPS_NUM_CMP; gi = gi + 1) begin : g_cmp_sync
            always @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    cmp_meta_reg[gi] <= 1'b0;
                    cmp_sync_reg[gi] <= 1'b0;
                end else if (clk_en) begin
                    cmp_meta_reg[gi] <= cmp_raw[gi];
                    cmp_sync_reg[gi] <= cmp_meta_reg[gi];
                end
            end
        end
    endgenerate

    // enable off flag has its own synchronizer outside the vector
    reg en_off_meta_reg;
    reg en_off_sync_reg;

    wire en_on_s      = cmp_sync_reg[0];
    wire vin_rise_s   = cmp_sync_reg[1];
    wire vin_fall_s   = cmp_sync_reg[2];
    wire hot_s        = cmp_sync_reg[3];
    wire cool_s       = cmp_sync_reg[4];
    wire ov_s         = cmp_sync_reg[5];
    wire ov_rel_s     = cmp_sync_reg[6];
    wire win_above_s  = cmp_sync_reg[7];
    wire win_below_s  = cmp_sync_reg[8];
    wire fold_hi_s    = cmp_sync_reg[9];
    wire fold_lo_s    = cmp_sync_reg[10];
    wire peak_ilim_s  = cmp_sync_reg[11];
    wire pwm_trip_s   = cmp_sync_reg[12];
    wire sink_ilim_s  = cmp_sync_reg[13];
    wire ss_above_s   = cmp_sync_reg[14];
    wire zero_cross_s = cmp_sync_reg[15];

    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg         en_ok_reg;
    reg         vin_ok_reg;
    reg         hot_reg;
    reg         ov_reg;
    reg  [11:0] osc_cnt_reg;
    reg         sync_q1_reg;
    reg         sync_q2_reg;
    reg  [9:0]  sync_cnt_reg;
    reg  [9:0]  sync_per_reg;
    reg  [1:0]  fold_cnt_reg;
    reg  [12:0] hic_cnt_reg;
    reg  [10:0] ss_cnt_reg;
    reg  [10:0] pg_cnt_reg;
    reg         pg_reg;

    wire osc_tick  = (osc_cnt_reg + 12'd1) >= freq_set_period;
    wire sync_rise = sync_q1_reg & ~sync_q2_reg;
    wire sync_tick = sync_locked & (sync_cnt_reg == {1'b0, sync_per_reg[9:1]});
    wire cyc_base  = sync_locked ? sync_tick : osc_tick;
    wire cyc_start = cyc_base & ((fold_div == `BFPS_FOLD_FULL) |
                     ((fold_div == `BFPS_FOLD_HALF) & ~fold_cnt_reg[0]) |
                     ((fold_div == `BFPS_FOLD_QUARTER) & (fold_cnt_reg == 2'd0)));

    wire switching = ((state_reg == ST_SS) | (state_reg == ST_RUN)) & ~ov_reg;
    wire ls_cut    = zero_cross_s & (reverse_block | ~sync_locked);
    wire hic_done  = osc_tick & ((hic_cnt_reg + 13'd1) >= `BFPS_HICCUP_CYC);
    wire ss_done   = ss_cnt_reg >= `BFPS_SS_CYC;
    wire pg_win    = ~win_above_s & ~win_below_s &
                     ((state_reg == ST_SS) | (state_reg == ST_RUN));
    wire [10:0] pg_limit = pg_reg ? `BFPS_PG_FALL_CYC : `BFPS_PG_RISE_CYC;
    wire [10:0] lvl_a = (ss_cnt_reg < ext_ss_level) ? ss_cnt_reg : ext_ss_level;
    wire [10:0] lvl_min = (lvl_a < `BFPS_REF_LEVEL) ? lvl_a : `BFPS_REF_LEVEL;

    assign regulation_ok_out     = 1'b0;
    assign regulation_ok_oe      = ~pg_reg;
    assign continuous_conduction = sync_locked;
    assign hiccup_active         = (state_reg == ST_HIC);
    assign soft_start_active     = (state_reg == ST_SS);

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (en_ok_reg & vin_ok_reg & ~hot_reg)
                    state_next = ST_SS;
            end
            ST_SS: begin
                if (oc_count >= `BFPS_OC_LIMIT)
                    state_next = ST_HIC;
                else if (ss_done)
                    state_next = ST_RUN;
            end
            ST_RUN: begin
                if ((oc_count >= `BFPS_OC_LIMIT) | ~fold_hi_s)
                    state_next = ST_HIC;
            end
            ST_HIC: begin
                if (hic_done & ~peak_ilim_s)
                    state_next = ST_SS;
            end
            ST_TSD: begin
                if (~hot_reg)
                    state_next = ST_SS;
            end
            default: state_next = ST_OFF;
        endcase
        if (~en_ok_reg | ~vin_ok_reg)
            state_next = ST_OFF;
        else if (hot_reg)
            state_next = ST_TSD;
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            en_off_meta_reg <= 1'b0;
            en_off_sync_reg <= 1'b0;
            en_ok_reg       <= 1'b0;
            vin_ok_reg      <= 1'b0;
            hot_reg         <= 1'b0;
            ov_reg          <= 1'b0;
            state_reg       <= ST_OFF;
        end else if (clk_en) begin
            en_off_meta_reg <= en_below_off;
            en_off_sync_reg <= en_off_meta_reg;
            if (en_on_s)
                en_ok_reg <= 1'b1;
            else if (en_off_sync_reg)
                en_ok_reg <= 1'b0;
            if (vin_rise_s)
                vin_ok_reg <= 1'b1;
            else if (vin_fall_s)
                vin_ok_reg <= 1'b0;
            if (hot_s)
                hot_reg <= 1'b1;
            else if (cool_s)
                hot_reg <= 1'b0;
            if (ov_s)
                ov_reg <= 1'b1;
            else if (ov_rel_s)
                ov_reg <= 1'b0;
            state_reg <= state_next;
        end
    end

    // oscillator, external sync and foldback
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            osc_cnt_reg  <= 12'h000;
            sync_q1_reg  <= 1'b0;
            sync_q2_reg  <= 1'b0;
            sync_cnt_reg <= 10'h000;
            sync_per_reg <= 10'h000;
            sync_locked  <= 1'b0;
            fold_cnt_reg <= 2'd0;
            fold_div     <= `BFPS_FOLD_FULL;
        end else if (clk_en) begin
            osc_cnt_reg <= osc_tick ? 12'h000 : osc_cnt_reg + 12'd1;
            sync_q1_reg <= sync_clk_in;
            sync_q2_reg <= sync_q1_reg;
            if (sync_rise) begin
                sync_per_reg <= sync_cnt_reg;
                sync_cnt_reg <= 10'h001;
                sync_locked  <= (sync_cnt_reg >= SYNC_PER_MIN) &
                                (sync_cnt_reg <= SYNC_PER_MAX);
            end else begin
                if (sync_cnt_reg != 10'h3ff)
                    sync_cnt_reg <= sync_cnt_reg + 10'd1;
                if (sync_cnt_reg > SYNC_PER_MAX)
                    sync_locked <= 1'b0;
            end
            if (cyc_base)
                fold_cnt_reg <= fold_cnt_reg + 2'd1;
            if (state_reg != ST_SS)
                fold_div <= `BFPS_FOLD_FULL;
            else if (fold_hi_s)
                fold_div <= `BFPS_FOLD_FULL;
            else if (fold_lo_s)
                fold_div <= `BFPS_FOLD_HALF;
            else
                fold_div <= `BFPS_FOLD_QUARTER;
        end
    end

    // soft start ramp, hiccup timer, reference selection
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ss_cnt_reg    <= 11'h000;
            hic_cnt_reg   <= 13'h0000;
            reverse_block <= 1'b0;
            target_level  <= 11'h000;
        end else if (clk_en) begin
            if ((state_reg != ST_SS) & (state_reg != ST_RUN))
                ss_cnt_reg <= 11'h000;
            else if (osc_tick & ~ss_done)
                ss_cnt_reg <= ss_cnt_reg + 11'd1;
            if (state_reg != ST_HIC)
                hic_cnt_reg <= 13'h0000;
            else if (hic_done)
                hic_cnt_reg <= 13'h0000;
            else if (osc_tick)
                hic_cnt_reg <= hic_cnt_reg + 13'd1;
            if ((state_next == ST_SS) & (state_reg != ST_SS))
                reverse_block <= 1'b1;
            else if (ss_above_s | (state_reg == ST_OFF))
                reverse_block <= 1'b0;
            target_level <= lvl_min;
        end
    end

    // gate drive and overcurrent counting
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hs_gate  <= 1'b0;
            ls_gate  <= 1'b0;
            oc_count <= 4'h0;
        end else if (clk_en) begin
            if (~switching) begin
                hs_gate <= 1'b0;
                ls_gate <= 1'b0;
            end else if (cyc_start) begin
                hs_gate <= 1'b1;
                ls_gate <= 1'b0;
            end else if (sink_ilim_s) begin
                hs_gate <= 1'b0;
                ls_gate <= 1'b0;
            end else if (hs_gate & (peak_ilim_s | pwm_trip_s)) begin
                hs_gate <= 1'b0;
                ls_gate <= ~ls_cut;
            end else if (ls_gate & ls_cut) begin
                ls_gate <= 1'b0;
            end
            if ((state_next == ST_HIC) | (state_reg == ST_OFF) |
                (state_reg == ST_TSD) | (state_reg == ST_HIC))
                oc_count <= 4'h0;
            else if (switching & hs_gate & peak_ilim_s & ~cyc_start &
                     (oc_count < `BFPS_OC_LIMIT))
                oc_count <= oc_count + 4'd1;
        end
    end

    // power-good deglitch in switching cycles
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pg_reg     <= 1'b0;
            pg_cnt_reg <= 11'h000;
        end else if (clk_en) begin
            if (pg_win == pg_reg)
                pg_cnt_reg <= 11'h000;
            else if (osc_tick) begin
                if ((pg_cnt_reg + 11'd1) >= pg_limit) begin
                    pg_reg     <= pg_win;
                    pg_cnt_reg <= 11'h000;
                end else
                    pg_cnt_reg <= pg_cnt_reg + 11'd1;
            end
        end
    end

endmodule

// >>> logic/bfps_regs.vh
// Purpose: constants for the buck fault, power-good and sequencing block
// Assumes: mclk at 125 MHz; comparator flags arrive asynchronous to mclk
// Notes:   counts are in switching (oscillator) cycles, except the sync periods, which are in mclk cycles
`ifndef BFPS_REGS_VH
`define BFPS_REGS_VH

`define BFPS_CLK_KHZ        125000
`define BFPS_SYNC_MIN_KHZ   200
`define BFPS_SYNC_MAX_KHZ   1400
`define BFPS_SYNC_PER_MIN   ((`BFPS_CLK_KHZ + `BFPS_SYNC_MAX_KHZ - 1) / `BFPS_SYNC_MAX_KHZ)
`define BFPS_SYNC_PER_MAX   (`BFPS_CLK_KHZ / `BFPS_SYNC_MIN_KHZ)

`define BFPS_PG_RISE_CYC    11'd1024
`define BFPS_PG_FALL_CYC    11'd16
`define BFPS_OC_LIMIT       4'd10
`define BFPS_HICCUP_CYC     13'd4096
`define BFPS_SS_CYC         11'd1600
`define BFPS_REF_LEVEL      11'd1600

`define BFPS_FOLD_FULL      2'd0
`define BFPS_FOLD_HALF      2'd1
`define BFPS_FOLD_QUARTER   2'd2

`define BFPS_NUM_CMP        16

`endif

// >>> tb/bfps_monitor.sv
// Purpose: port checker for the sequencer
// Assumes: one mclk domain; oscillator period read from freq_set_period
// Notes:   input counts lead the design by its synchronizer delay
module bfps_monitor (
    input wire        mclk,
    input wire        reset_n,
    input wire [11:0] freq_set_period,
    input wire        fb_over_ov,
    input wire        fb_above_window,
    input wire        fb_below_window,
    input wire        peak_ilim,
    input wire        sink_ilim,
    input wire        regulation_ok_oe,
    input wire        hs_gate,
    input wire        ls_gate,
    input wire        hiccup_active,
    input wire        soft_start_active,
    input wire [3:0]  oc_count
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    int  p;
    int  win_cnt;
    int  out_cnt;
    int  hic_cnt;
    wire out_w = fb_above_window | fb_below_window;
    assign p = (freq_set_period < 12'h002) ? 1 : freq_set_period;
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            win_cnt <= 0;
            out_cnt <= 0;
            hic_cnt <= 0;
        end else begin
            win_cnt <= out_w ? 0 : win_cnt + 1;
            out_cnt <= out_w ? out_cnt + 1 : 0;
            hic_cnt <= hiccup_active ? hic_cnt + 1 : 0;
        end
    end
    property p_pg_rise;
        $fell(regulation_ok_oe) |-> win_cnt >= 1023 * p;
    endproperty
    a_pg_rise: assert property (p_pg_rise) else $error("pg rose early");
    property p_pg_fall;
        $rose(regulation_ok_oe) && !hiccup_active && !soft_start_active |-> out_cnt >= 15 * p;
    endproperty
    a_pg_fall: assert property (p_pg_fall) else $error("pg fell early");
    property p_ilim;
        peak_ilim [*4] ##0 hs_gate |=> !hs_gate && ls_gate;
    endproperty
    a_ilim: assert property (p_ilim) else $error("peak limit swap");
    property p_oc_hic;
        oc_count == 4'ha |-> ##[1:4] hiccup_active;
    endproperty
    a_oc_hic: assert property (p_oc_hic) else $error("no hiccup at ten");
    property p_hic_off;
        hiccup_active [*2] |-> !hs_gate && !ls_gate && oc_count == 4'h0;
    endproperty
    a_hic_off: assert property (p_hic_off) else $error("switching in hiccup");
    property p_hic_len;
        $fell(hiccup_active) |-> hic_cnt >= 4095 * p;
    endproperty
    a_hic_len: assert property (p_hic_len) else $error("hiccup too short");
    property p_sink;
        sink_ilim [*5] |-> !ls_gate;
    endproperty
    a_sink: assert property (p_sink) else $error("low side on at sink limit");
    property p_ov;
        fb_over_ov [*5] |-> !hs_gate && !ls_gate;
    endproperty
    a_ov: assert property (p_ov) else $error("switching in overvoltage");
endmodule
bind bfps_sequencer bfps_monitor u_mon (.mclk, .reset_n, .freq_set_period, .fb_over_ov,
    .fb_above_window, .fb_below_window, .peak_ilim, .sink_ilim, .regulation_ok_oe,
    .hs_gate, .ls_gate, .hiccup_active, .soft_start_active, .oc_count);

// >>> tb/bfps_analog_model.sv
// Purpose: comparator and power stage stand-in for the sequencer
// Assumes: feedback given in millivolts, 0.6 V target, 1600 = full target
// Notes:   peak trip fires two cycles into each high-side pulse
module bfps_analog_model (
    input wire        mclk,
    input int         fb_mv,
    input wire        hs_gate,
    input wire [10:0] target_level,
    output logic      fb_over_ov,
    output logic      fb_below_ov_release,
    output logic      fb_above_window,
    output logic      fb_below_window,
    output logic      fb_above_fold_hi,
    output logic      fb_above_fold_lo,
    output logic      ss_above_fb,
    output logic      pwm_peak_trip
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] hs_d = 2'h0;
    always @(posedge mclk) hs_d <= {hs_d[0], hs_gate};
    always @* begin
        fb_over_ov = fb_mv >= 700;
        fb_below_ov_release = fb_mv <= 630;
        fb_above_window = fb_mv > 630;
        fb_below_window = fb_mv < 570;
        fb_above_fold_hi = fb_mv >= 400;
        fb_above_fold_lo = fb_mv >= 200;
        ss_above_fb = target_level * 3 / 8 > fb_mv;
        pwm_peak_trip = hs_d[1];
    end
endmodule

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the sequencer
// Assumes: oscillator period of P mclk cycles, mclk at 125 MHz
// Notes:   scenarios run in order on one running regulator
`include "bfps_regs.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P = 4;
    logic mclk = 0, reset_n = 0, sync_clk_in = 0, peak_ilim = 0, sink_ilim = 0;
    logic en_above_on = 0, en_below_off = 1, vin_above_rise = 0, vin_below_fall = 1;
    logic temp_over_hot = 0, temp_below_cool = 1, zero_cross = 0;
    logic [10:0] ext_ss_level = 11'h7ff;
    int fb_mv = 100, cyc = 0, c, t0, k, bad_count = 0, n_tests = 0;
    logic fb_over_ov, fb_below_ov_release, fb_above_window, fb_below_window;
    logic fb_above_fold_hi, fb_above_fold_lo, ss_above_fb, pwm_peak_trip;
    logic regulation_ok_out, regulation_ok_oe, hs_gate, ls_gate, continuous_conduction;
    logic reverse_block, hiccup_active, soft_start_active, sync_locked;
    logic [10:0] target_level;
    logic [3:0] oc_count;
    logic [1:0] fold_div;
    wire pg_pin = regulation_ok_oe ? regulation_ok_out : 1'b1;
    bfps_sequencer DUT (.mclk, .reset_n, .clk_en(1'b1), .freq_set_period(12'(P)),
        .sync_clk_in, .en_above_on, .en_below_off, .vin_above_rise, .vin_below_fall,
        .temp_over_hot, .temp_below_cool, .fb_over_ov, .fb_below_ov_release,
        .fb_above_window, .fb_below_window, .fb_above_fold_hi, .fb_above_fold_lo,
        .peak_ilim, .pwm_peak_trip, .sink_ilim, .zero_cross, .ss_above_fb,
        .ext_ss_level, .regulation_ok_in(pg_pin), .regulation_ok_out, .regulation_ok_oe,
        .hs_gate, .ls_gate, .target_level, .continuous_conduction, .reverse_block,
        .hiccup_active, .soft_start_active, .oc_count, .sync_locked, .fold_div);
    bfps_analog_model u_model (.mclk, .fb_mv, .hs_gate, .target_level, .fb_over_ov,
        .fb_below_ov_release, .fb_above_window, .fb_below_window, .fb_above_fold_hi,
        .fb_above_fold_lo, .ss_above_fb, .pwm_peak_trip);
    initial forever #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic tk(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wt(ref logic s, input logic v, input int lim);
        for (c = 0; c < lim && s !== v; c++) @(posedge mclk);
    endtask
    task automatic t_start;
        `CHK("pg_reset", 1'b0, pg_pin)
        `CHK("gates_reset", 2'b00, {hs_gate, ls_gate})
        en_above_on <= 1;
        en_below_off <= 0;
        vin_above_rise <= 1;
        vin_below_fall <= 0;
        wt(soft_start_active, 1, 20);
        t0 = cyc;
        `CHK("ss_on", 1'b1, soft_start_active)
        tk(12);
        `CHK("fold_q", `BFPS_FOLD_QUARTER, fold_div)
        fb_mv <= 300;
        tk(12);
        `CHK("fold_h", `BFPS_FOLD_HALF, fold_div)
        fb_mv <= 590;
        tk(12);
        `CHK("fold_f", `BFPS_FOLD_FULL, fold_div)
        `CHK("rev_on", 1'b1, reverse_block)
        wt(regulation_ok_oe, 0, 1100 * P);
        `CHK("pg_rise", 1'b1, c >= 1020 * P && c < 1100 * P)
        wt(soft_start_active, 0, 1700 * P);
        `CHK("ss_len", 1'b1, cyc - t0 >= 1599 * P && cyc - t0 <= 1601 * P + 4)
        `CHK("target", `BFPS_REF_LEVEL, target_level)
        `CHK("rev_off", 1'b0, reverse_block)
        ext_ss_level <= 11'h100;
        tk(8);
        `CHK("target_ext", 11'h100, target_level)
        ext_ss_level <= 11'h7ff;
    endtask
    task automatic t_pg;
        for (k = 0; k < 2; k++) begin
            fb_mv <= k ? 640 : 560;
            tk(10 * P);
            fb_mv <= 590;
            tk(8);
            `CHK("pg_glitch", 1'b1, pg_pin)
            fb_mv <= k ? 640 : 560;
            wt(regulation_ok_oe, 1, 20 * P);
            `CHK("pg_fall", 1'b1, c >= 15 * P && c <= 17 * P + 6)
            tk(100 * P);
            `CHK("pg_held", 1'b0, pg_pin)
            fb_mv <= 590;
            wt(regulation_ok_oe, 0, 1100 * P);
            `CHK("pg_back", 1'b1, pg_pin)
        end
    endtask
    task automatic t_ov_sink;
        fb_mv <= 720;
        tk(8);
        `CHK("ov_off", 2'b00, {hs_gate, ls_gate})
        fb_mv <= 650;
        tk(3 * P + 8);
        `CHK("ov_hold", 2'b00, {hs_gate, ls_gate})
        fb_mv <= 590;
        wt(hs_gate, 1, 4 * P + 10);
        `CHK("ov_resume", 1'b1, hs_gate)
        wt(ls_gate, 1, 8);
        `CHK("swap", 2'b01, {hs_gate, ls_gate})
        sink_ilim <= 1;
        tk(6);
        `CHK("sink_off", 1'b0, ls_gate)
        tk(2 * P);
        `CHK("sink_hold", 1'b0, ls_gate)
        sink_ilim <= 0;
        wt(ls_gate, 1, 3 * P + 8);
        `CHK("sink_resume", 1'b1, ls_gate)
    endtask
    task automatic t_fault;
        for (k = 0; k < 2; k++) begin
            vin_above_rise <= k[0];
            vin_below_fall <= !k[0];
            temp_over_hot <= k[0];
            temp_below_cool <= !k[0];
            tk(8);
            `CHK("fault_off", 3'b000, {hs_gate, ls_gate, soft_start_active})
            vin_below_fall <= 0;
            temp_over_hot <= 0;
            tk(8);
            `CHK("fault_hold", 3'b000, {hs_gate, ls_gate, soft_start_active})
            vin_above_rise <= 1;
            temp_below_cool <= 1;
            wt(soft_start_active, 1, 20);
            `CHK("fault_ss", 1'b1, soft_start_active)
        end
        zero_cross <= 1;
        wt(ls_gate, 1, 4 * P + 8);
        `CHK("precharge", 2'b10, {reverse_block, ls_gate})
        zero_cross <= 0;
    endtask
    task automatic t_sync;
        for (k = 0; k < 8; k++) begin
            sync_clk_in <= 1;
            tk(100);
            sync_clk_in <= 0;
            tk(100);
        end
        `CHK("lock", 1'b1, sync_locked)
        `CHK("ccm", 1'b1, continuous_conduction)
        sync_clk_in <= 1;
        for (c = 0; c < 200 && hs_gate !== 1'b1; c++) begin
            @(posedge mclk);
            if (c == 99) sync_clk_in <= 0;
        end
        `CHK("phase", 1'b1, c >= 100 && c <= 108)
        zero_cross <= 1;
        tk(12);
        `CHK("ccm_keep_ls", 1'b1, ls_gate)
        tk(700);
        `CHK("unlock", 1'b0, sync_locked)
        wt(ls_gate, 1, 4 * P + 4);
        `CHK("dcm_cut", 1'b0, ls_gate)
        zero_cross <= 0;
    endtask
    task automatic t_hic;
        peak_ilim <= 1;
        for (c = 0; c < 12 * P + 20 && oc_count !== 4'ha; c++) @(posedge mclk);
        `CHK("oc_ten", 1'b1, c < 12 * P + 20)
        wt(hiccup_active, 1, 8);
        `CHK("hic_on", 1'b1, hiccup_active)
        tk(4);
        `CHK("oc_clear", 4'h0, oc_count)
        tk(4096 * P + 20);
        `CHK("hic_again", 1'b1, hiccup_active)
        peak_ilim <= 0;
        wt(hiccup_active, 0, 4097 * P + 10);
        `CHK("hic_exit", 1'b1, soft_start_active)
    endtask
    task automatic summarize;
        $display("tests %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        reset_n <= 1;
        @(posedge mclk);
        t_start();
        t_pg();
        t_ov_sink();
        t_sync();
        t_fault();
        t_hic();
        summarize();
    end
endmodule
